//--- design/misc_control_command_regs.v
`timescale 1ns/1ps
`include "misc_control_regs.vh"

module misc_control_command_regs #(
  parameter SETTLE_CYC = `ST_SETTLE_MS * 1000 * `CLK_MHZ,
  parameter PER_W = 24,
  parameter [13:0] ST_LIMIT = 14'h015e
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // serial port
  input wire sclk_in,
  input wire cs_n_in,
  input wire mosi_in,
  output reg miso_out,
  // io lines
  input wire io_line_one_in,
  output reg io_line_one_out,
  output reg io_line_one_oe_out,
  input wire io_line_two_in,
  output reg io_line_two_out,
  output reg io_line_two_oe_out,
  // sensor core
  input wire sample_tick_in,
  input wire [13:0] x_accel_output_in,
  input wire [13:0] y_accel_output_in,
  input wire [15:0] status_event_in,
  output reg self_test_drive_out,
  output reg [13:0] x_accel_offset_out,
  output reg [13:0] y_accel_offset_out,
  // aux level, flash and soft reset
  output reg [11:0] aux_level_code_out,
  output reg flash_backup_req_out,
  input wire flash_fail_in,
  output reg soft_reset_out
);

  // ==========================================
  // serial port and io line synchronisers
  reg sclk_m_q, sclk_s_q, sclk_d_q;
  reg cs_m_q, cs_s_q, cs_d_q;
  reg mosi_m_q, mosi_s_q;
  reg io1_m_q, io1_s_q, io2_m_q, io2_s_q;

  always @(posedge clk_in) begin
    if (reset_in) begin
      sclk_m_q <= 1'b1;
      sclk_s_q <= 1'b1;
      sclk_d_q <= 1'b1;
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      mosi_m_q <= 1'b0;
      mosi_s_q <= 1'b0;
      io1_m_q <= 1'b0;
      io1_s_q <= 1'b0;
      io2_m_q <= 1'b0;
      io2_s_q <= 1'b0;
    end else begin
      sclk_m_q <= sclk_in;
      sclk_s_q <= sclk_m_q;
      sclk_d_q <= sclk_s_q;
      cs_m_q <= cs_n_in;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      mosi_m_q <= mosi_in;
      mosi_s_q <= mosi_m_q;
      io1_m_q <= io_line_one_in;
      io1_s_q <= io1_m_q;
      io2_m_q <= io_line_two_in;
      io2_s_q <= io2_m_q;
    end
  end

  wire sclk_rise = sclk_s_q & ~sclk_d_q;
  wire sclk_fall = ~sclk_s_q & sclk_d_q;
  wire frame_start = ~cs_s_q & cs_d_q;
  wire frame_end = cs_s_q & ~cs_d_q;
  wire in_frame = ~cs_s_q;

  // ==========================================
  // shift registers
  reg [15:0] rx_q, tx_q, resp_q;
  reg [4:0] bit_cnt_q;

  always @(posedge clk_in) begin
    if (reset_in) begin
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
      miso_out <= 1'b0;
    end else if (frame_start) begin
      tx_q <= resp_q;
      bit_cnt_q <= 5'h00;
    end else if (in_frame && sclk_fall) begin
      miso_out <= tx_q[15];
      tx_q <= {tx_q[14:0], 1'b0};
    end else if (in_frame && sclk_rise) begin
      rx_q <= {rx_q[14:0], mosi_s_q};
      if (bit_cnt_q != 5'h11) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // a frame counts only with exactly sixteen bits; short or long frames are dropped
  wire word_done = frame_end && (bit_cnt_q == 5'h10);
  wire is_write = rx_q[15];
  wire [6:0] base = {rx_q[14:9], 1'b0};
  wire hi_byte = rx_q[8];
  wire [7:0] wdata = rx_q[7:0];
  wire wr_en = word_done & is_write;
  wire rd_en = word_done & ~is_write;

  // ==========================================
  // registers
  reg [15:0] misc_q, gpio_q, status_q;
  reg [11:0] aux_q;
  reg cmd_srst_q;
  wire int_rst = reset_in | cmd_srst_q;
  wire [15:0] mc_mask = `MC_MASK;

  wire cmd_wr = wr_en && base == `ADDR_COMMAND && !hi_byte;
  wire do_null = cmd_wr & wdata[`CMD_AUTONULL];
  wire do_restore = cmd_wr & wdata[`CMD_RESTORE];
  wire do_latch = cmd_wr & wdata[`CMD_LATCH];
  wire do_flash = cmd_wr & wdata[`CMD_FLASH];
  wire do_clr = cmd_wr & wdata[`CMD_CLR_STAT];
  wire do_srst = cmd_wr & wdata[`CMD_SW_RESET];

  always @(posedge clk_in) begin
    if (int_rst) begin
      misc_q <= `MISC_CTRL_RST;
      gpio_q <= `GPIO_CTRL_RST;
      aux_q <= `AUX_LEVEL_RST;
    end else if (wr_en) begin
      if (base == `ADDR_MISC_CTRL) begin
        if (hi_byte) begin
          misc_q[15:8] <= wdata & mc_mask[15:8];
        end else begin
          misc_q[7:0] <= wdata & mc_mask[7:0];
        end
      end
      if (base == `ADDR_GPIO_CTRL) begin
        if (hi_byte) begin
          gpio_q[9:8] <= wdata[1:0];
        end else begin
          gpio_q[1:0] <= wdata[1:0];
        end
      end
      if (base == `ADDR_AUX_LEVEL) begin
        if (hi_byte) begin
          aux_q[11:8] <= wdata[3:0];
        end else begin
          aux_q[7:0] <= wdata;
        end
      end
    end
  end

  // ==========================================
  // command pulses and outputs
  always @(posedge clk_in) begin
    if (reset_in) begin
      cmd_srst_q <= 1'b0;
      soft_reset_out <= 1'b0;
      flash_backup_req_out <= 1'b0;
      aux_level_code_out <= `AUX_LEVEL_RST;
      x_accel_offset_out <= 14'h0000;
      y_accel_offset_out <= 14'h0000;
    end else begin
      cmd_srst_q <= do_srst;
      soft_reset_out <= do_srst;
      flash_backup_req_out <= do_flash;
      if (cmd_srst_q) begin
        aux_level_code_out <= `AUX_LEVEL_RST;
      end else if (do_latch) begin
        aux_level_code_out <= aux_q;
      end
      if (do_null) begin
        x_accel_offset_out <= 14'h0000 - x_accel_output_in;
        y_accel_offset_out <= 14'h0000 - y_accel_output_in;
      end else if (do_restore) begin
        x_accel_offset_out <= 14'h0000;
        y_accel_offset_out <= 14'h0000;
      end
    end
  end

  // ==========================================
  // power-on self-test
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_OFF = 4'h2;
  localparam [3:0] ST_ON = 4'h4;
  localparam [3:0] ST_CHK = 4'h8;
  reg [3:0] st_q;
  reg [31:0] st_cnt_q;
  reg [13:0] x0_q, y0_q;
  reg st_fail_q, st_start_q;
  wire [13:0] dx = x_accel_output_in - x0_q;
  wire [13:0] dy = y_accel_output_in - y0_q;
  wire [13:0] adx = dx[13] ? 14'h0000 - dx : dx;
  wire [13:0] ady = dy[13] ? 14'h0000 - dy : dy;
  wire settled = st_cnt_q >= SETTLE_CYC - 1;

  always @(posedge clk_in) begin
    if (int_rst) begin
      st_q <= ST_IDLE;
      st_cnt_q <= 32'h0000_0000;
      x0_q <= 14'h0000;
      y0_q <= 14'h0000;
      st_fail_q <= 1'b0;
      st_start_q <= 1'b1;
    end else begin
      st_fail_q <= 1'b0;
      st_start_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // bit 10 low means the start-up test runs
          if (st_start_q && !misc_q[`MC_POST_DIS]) begin
            st_q <= ST_OFF;
            st_cnt_q <= 32'h0000_0000;
          end
        end
        ST_OFF: begin
          st_cnt_q <= st_cnt_q + 32'h0000_0001;
          if (settled) begin
            x0_q <= x_accel_output_in;
            y0_q <= y_accel_output_in;
            st_cnt_q <= 32'h0000_0000;
            st_q <= ST_ON;
          end
        end
        ST_ON: begin
          st_cnt_q <= st_cnt_q + 32'h0000_0001;
          if (settled) begin
            st_q <= ST_CHK;
          end
        end
        ST_CHK: begin
          st_fail_q <= (adx < ST_LIMIT) | (ady < ST_LIMIT);
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // status, set beats clear
  reg [15:0] set_vec, clr_vec;
  always @* begin
    set_vec = status_event_in & `STATUS_EXT_MASK;
    set_vec[`ST_SELF_FAIL] = st_fail_q;
    set_vec[`ST_FLASH_FAIL] = flash_fail_in;
    clr_vec = 16'h0000;
    if (do_clr) begin
      clr_vec = 16'hffff;
    end else if (rd_en && base == `ADDR_STATUS) begin
      clr_vec[`ST_FLASH_FAIL] = 1'b1;
    end
  end

  always @(posedge clk_in) begin
    if (int_rst) begin
      status_q <= `STATUS_RST;
    end else begin
      status_q <= (status_q & ~clr_vec) | set_vec;
    end
  end

  // ==========================================
  // read response for the next frame
  reg [15:0] rdata;
  always @* begin
    case (base)
      `ADDR_MISC_CTRL: rdata = misc_q;
      `ADDR_GPIO_CTRL: rdata = {6'h00, io2_s_q, io1_s_q, 6'h00, gpio_q[1:0]};
      `ADDR_AUX_LEVEL: rdata = {4'h0, aux_q};
      `ADDR_STATUS: rdata = status_q;
      default: rdata = 16'h0000;
    endcase
  end

  always @(posedge clk_in) begin
    if (int_rst) begin
      resp_q <= 16'h0000;
    end else if (rd_en) begin
      resp_q <= rdata;
    end
  end

  // ==========================================
  // data-ready timing: period measured between sample ticks
  reg [PER_W-1:0] per_cnt_q, per_q, el_q;
  reg dr_act_q;
  always @(posedge clk_in) begin
    if (int_rst) begin
      per_cnt_q <= {PER_W{1'b0}};
      per_q <= {PER_W{1'b0}};
      el_q <= {PER_W{1'b0}};
      dr_act_q <= 1'b0;
    end else if (sample_tick_in) begin
      per_q <= per_cnt_q + 1'b1;
      per_cnt_q <= {PER_W{1'b0}};
      el_q <= {PER_W{1'b0}};
      dr_act_q <= 1'b1;
    end else begin
      per_cnt_q <= per_cnt_q + 1'b1;
      el_q <= el_q + 1'b1;
      if (el_q + 1'b1 >= (per_q >> 2)) begin
        dr_act_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // io line drivers
  wire dr_en = misc_q[`MC_DR_EN];
  wire dr_one = dr_en & ~misc_q[`MC_DR_SEL];
  wire dr_two = dr_en & misc_q[`MC_DR_SEL];
  wire dr_lvl = misc_q[`MC_DR_POL] ? dr_act_q : ~dr_act_q;

  always @(posedge clk_in) begin
    if (int_rst) begin
      io_line_one_out <= 1'b0;
      io_line_one_oe_out <= 1'b0;
      io_line_two_out <= 1'b0;
      io_line_two_oe_out <= 1'b0;
      self_test_drive_out <= 1'b0;
    end else begin
      io_line_one_oe_out <= dr_one | gpio_q[`GC_DIR1];
      io_line_one_out <= dr_one ? dr_lvl : gpio_q[`GC_DAT1];
      io_line_two_oe_out <= dr_two | gpio_q[`GC_DIR2];
      io_line_two_out <= dr_two ? dr_lvl : gpio_q[`GC_DAT2];
      self_test_drive_out <= misc_q[`MC_ST_EN] | (st_q == ST_ON);
    end
  end

endmodule

//--- design/misc_control_regs.vh
`ifndef MISC_CONTROL_REGS_VH
`define MISC_CONTROL_REGS_VH
// ==========================================
// clock and timing
`define CLK_MHZ 100
`define ST_SETTLE_MS 20
// ==========================================
// register byte addresses (even = low byte)
`define ADDR_AUX_LEVEL 7'h30
`define ADDR_MISC_CTRL 7'h34
`define ADDR_GPIO_CTRL 7'h36
`define ADDR_STATUS 7'h3c
`define ADDR_COMMAND 7'h3e
// ==========================================
// reset values
`define MISC_CTRL_RST 16'h0000
`define GPIO_CTRL_RST 16'h0000
`define AUX_LEVEL_RST 12'h000
`define STATUS_RST 16'h0000
// ==========================================
// misc control fields
`define MC_DR_SEL 0
`define MC_DR_POL 1
`define MC_DR_EN 2
`define MC_ST_EN 8
`define MC_POST_DIS 10
`define MC_MASK 16'h0507
// ==========================================
// general io control fields
`define GC_DIR1 0
`define GC_DIR2 1
`define GC_DAT1 8
`define GC_DAT2 9
// ==========================================
// command bits
`define CMD_AUTONULL 0
`define CMD_RESTORE 1
`define CMD_LATCH 2
`define CMD_FLASH 3
`define CMD_CLR_STAT 4
`define CMD_SW_RESET 7
// ==========================================
// status fields
`define ST_FLASH_FAIL 2
`define ST_SELF_FAIL 5
`define STATUS_EXT_MASK 16'h030b
`endif

//--- tb/misc_control_command_regs_test.sv
`timescale 1ns/1ps
`include "misc_control_regs.vh"
// ==========
// bench top
module misc_control_command_regs_test;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sclk, cs_n, mosi, miso, o1, e1, o2, e2, st_drv, fl_req, sw_rst;
  logic pin_one = 1'b0;
  logic pin_two = 1'b1;
  logic tick = 1'b0;
  logic fl_fail = 1'b0;
  logic [13:0] x_acc = 14'h0100;
  logic [13:0] y_acc = 14'h0200;
  logic [13:0] x_off, y_off;
  logic [15:0] ev = 16'h0000;
  // sensor answers the stimulus only when this is set
  logic resp_on = 1'b0;
  wire [13:0] x_in = (resp_on && st_drv) ? x_acc + 14'h0190 : x_acc;
  wire [13:0] y_in = (resp_on && st_drv) ? y_acc + 14'h0190 : y_acc;
  logic [11:0] aux;
  logic [15:0] r, v;
  wire line_one = e1 ? o1 : pin_one;
  wire line_two = e2 ? o2 : pin_two;
  integer failures = 0;
  integer tests_run = 0;
  integer tcnt = 0;
  integer i, n;
  always #5 clk_in = ~clk_in;
  // 40-clock sample period, so a quarter is 10 clocks
  always @(posedge clk_in) begin
    tcnt <= (tcnt == 39) ? 0 : tcnt + 1;
    tick <= (tcnt == 39);
  end
  spi_host host (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  misc_control_command_regs #(.SETTLE_CYC(20)) uut (.clk_in(clk_in), .reset_in(reset_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso), .io_line_one_in(line_one),
    .io_line_one_out(o1), .io_line_one_oe_out(e1), .io_line_two_in(line_two), .io_line_two_out(o2),
    .io_line_two_oe_out(e2), .sample_tick_in(tick), .x_accel_output_in(x_in),
    .y_accel_output_in(y_in), .status_event_in(ev), .self_test_drive_out(st_drv),
    .x_accel_offset_out(x_off), .y_accel_offset_out(y_off), .aux_level_code_out(aux),
    .flash_backup_req_out(fl_req), .flash_fail_in(fl_fail), .soft_reset_out(sw_rst));
  function logic [15:0] neg14(input logic [13:0] a);
    neg14 = {2'b00, ~a + 14'h0001};
  endfunction
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        failures++;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr16(input logic [6:0] a, input logic [15:0] d);
    begin
      host.xfer({1'b1, a, d[7:0]}, r);
      host.xfer({1'b1, a | 7'h01, d[15:8]}, r);
    end
  endtask
  // answer comes back in the following frame
  task rd16(input logic [6:0] a, output logic [15:0] d);
    begin
      host.xfer({1'b0, a, 8'h00}, d);
      host.xfer(16'h0000, d);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h5872));
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    // steady accel during power-on test means no response
    repeat (100) @(posedge clk_in);
    rd16(`ADDR_STATUS, v);
    cmp(v, 16'h0020);
    // external flags are sticky, so clear must take them too
    @(posedge clk_in) ev <= 16'hffff;
    @(posedge clk_in) ev <= 16'h0000;
    rd16(`ADDR_STATUS, v);
    cmp(v, 16'h032b);
    wr16(`ADDR_COMMAND, 16'h0010);
    rd16(`ADDR_STATUS, v);
    cmp(v, 16'h0000);
    @(posedge clk_in) fl_fail <= 1'b1;
    @(posedge clk_in) fl_fail <= 1'b0;
    rd16(`ADDR_STATUS, v);
    cmp(v, 16'h0004);
    rd16(`ADDR_STATUS, v);
    cmp(v, 16'h0000);
    n = 0;
    fork
      host.xfer(16'hbe68, r);
      repeat (400) @(posedge clk_in) n += fl_req + 2 * sw_rst;
    join
    cmp(16'(n), 16'h0001);
    rd16(`ADDR_COMMAND, v);
    cmp(v, 16'h0000);
    rd16(7'h10, v);
    cmp(v, 16'h0000);
    v = 16'($urandom);
    wr16(`ADDR_AUX_LEVEL, v | 16'hf000);
    cmp({4'h0, aux}, 16'h0000);
    rd16(`ADDR_AUX_LEVEL, r);
    cmp(r, v & 16'h0fff);
    wr16(`ADDR_COMMAND, 16'h0004);
    cmp({4'h0, aux}, v & 16'h0fff);
    {x_acc, y_acc} <= 28'($urandom);
    wr16(`ADDR_COMMAND, 16'h0001);
    cmp({2'b00, x_off}, neg14(x_acc));
    cmp({2'b00, y_off}, neg14(y_acc));
    wr16(`ADDR_COMMAND, 16'h0002);
    cmp({2'b00, x_off | y_off}, 16'h0000);
    wr16(`ADDR_MISC_CTRL, 16'h0100);
    repeat (300) @(posedge clk_in);
    cmp({15'h0, st_drv}, 16'h0001);
    wr16(`ADDR_MISC_CTRL, 16'h0000);
    cmp({15'h0, st_drv}, 16'h0000);
    pin_one <= 1'($urandom);
    wr16(`ADDR_GPIO_CTRL, 16'h0102);
    cmp({13'h0, e2, o2, e1}, 16'h0004);
    rd16(`ADDR_GPIO_CTRL, r);
    cmp(r, {7'h0, pin_one, 8'h02});
    wr16(`ADDR_GPIO_CTRL, 16'h0303);
    cmp({12'h0, e2, o2, e1, o1}, 16'h000f);
    // lines idle high as outputs, so the pulse must override them
    for (i = 4; i < 8; i++) begin
      wr16(`ADDR_MISC_CTRL, 16'(i));
      repeat (90) @(posedge clk_in);
      n = 0;
      repeat (40) @(posedge clk_in) n += ((i[0] ? line_two : line_one) == i[1]);
      cmp(16'(n), 16'h000a);
      cmp({15'h0, i[0] ? e2 : e1}, 16'h0001);
    end
    resp_on <= 1'b1;
    wr16(`ADDR_COMMAND, 16'h0080);
    rd16(`ADDR_MISC_CTRL, v);
    cmp(v, 16'h0000);
    cmp({4'h0, aux}, 16'h0000);
    // restart reruns the start-up test, which now sees a response
    rd16(`ADDR_STATUS, v);
    cmp(v, 16'h0000);
    complete_run;
  end
endmodule

//--- tb/misc_ctrl_asserts.sv
`timescale 1ns/1ps
// ==========
// port checks
module misc_ctrl_asserts (
  // clock, reset, select
  input logic clk_in,
  input logic reset_in,
  input logic cs_n_in,
  // sensor core
  input logic [13:0] x_accel_output_in,
  input logic [13:0] y_accel_output_in,
  input logic self_test_drive_out,
  input logic [13:0] x_accel_offset_out,
  input logic [13:0] y_accel_offset_out,
  // aux, flash, restart
  input logic [11:0] aux_level_code_out,
  input logic flash_backup_req_out,
  input logic soft_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_rst_clear;
    $fell(reset_in) |-> aux_level_code_out == 12'h000 && x_accel_offset_out == 14'h0000 && !soft_reset_out;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
  property p_post_start;
    $fell(reset_in) |-> ##[20:30] self_test_drive_out;
  endproperty
  a_post_start: assert property (p_post_start) else $error("no power-on test");
  property p_soft_post;
    soft_reset_out |-> ##[20:30] self_test_drive_out;
  endproperty
  a_soft_post: assert property (p_soft_post) else $error("restart skipped test");
  property p_soft_pulse;
    soft_reset_out |=> !soft_reset_out;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("restart not single");
  property p_flash;
    flash_backup_req_out |-> $past(cs_n_in, 2) ##1 !flash_backup_req_out;
  endproperty
  a_flash: assert property (p_flash) else $error("bad backup request");
  // output may only move after a frame has closed
  property p_aux_latch;
    !$stable(aux_level_code_out) |-> $past(cs_n_in, 2);
  endproperty
  a_aux_latch: assert property (p_aux_latch) else $error("level moved mid frame");
  property p_xoff;
    !$stable(x_accel_offset_out) |-> x_accel_offset_out == 14'h0000
      || x_accel_offset_out == ~$past(x_accel_output_in) + 14'h0001;
  endproperty
  a_xoff: assert property (p_xoff) else $error("bad x offset");
  property p_yoff;
    !$stable(y_accel_offset_out) |-> y_accel_offset_out == 14'h0000
      || y_accel_offset_out == ~$past(y_accel_output_in) + 14'h0001;
  endproperty
  a_yoff: assert property (p_yoff) else $error("bad y offset");
endmodule
bind misc_control_command_regs misc_ctrl_asserts chk (.clk_in(clk_in), .reset_in(reset_in),
  .cs_n_in(cs_n_in), .x_accel_output_in(x_accel_output_in), .y_accel_output_in(y_accel_output_in),
  .self_test_drive_out(self_test_drive_out), .x_accel_offset_out(x_accel_offset_out),
  .y_accel_offset_out(y_accel_offset_out), .aux_level_code_out(aux_level_code_out),
  .flash_backup_req_out(flash_backup_req_out), .soft_reset_out(soft_reset_out));

//--- tb/spi_host.sv
`timescale 1ns/1ps
// ==========
// mode 3 host, 16 clocks per sclk period
module spi_host (
  // clock
  input wire clk_in,
  // serial port
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire miso_in
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    integer i;
    begin
      @(posedge clk_in) cs_n_out <= 1'b0;
      for (i = 15; i >= 0; i--) begin
        repeat (8) @(posedge clk_in);
        sclk_out <= 1'b0;
        mosi_out <= w[i];
        repeat (8) @(posedge clk_in);
        sclk_out <= 1'b1;
        r[i] = miso_in;
      end
      repeat (8) @(posedge clk_in);
      cs_n_out <= 1'b1;
      // released line must not look like the last bit
      mosi_out <= ~mosi_out;
      repeat (24) @(posedge clk_in);
    end
  endtask
endmodule
